// File: design/ext_bus_map.svh
// Constants for the external bus and system pin block
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH
`define ADDR_W 24
`define DATA_W 16
`define AREA_HI 23
`define AREA_LO 21
`define AREA_N 8
`define MODE_TOP 2
`define MODE_ADDR_W 3
`define ACC_CYCLES 4'h2
`define WAIT_LIMIT 4'hf
`endif

// File: design/ext_bus_pkg.sv
// Types for the external bus and system pin block
package ext_bus_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_DATA = 3'b010,
    ST_DONE = 3'b011,
    ST_RELEASED = 3'b100
  } bus_state_e;
  typedef enum logic [2:0] {
    MODE_NONE = 3'b000,
    MODE_4 = 3'b100,
    MODE_5 = 3'b101,
    MODE_6 = 3'b110,
    MODE_7 = 3'b111
  } op_mode_e;
endpackage

// File: design/area_cfg_mem.sv
// Small per-area configuration memory: 3-state access flag per area
`timescale 1ns/1ps
`include "ext_bus_map.svh"
module area_cfg_mem (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [`MODE_ADDR_W-1:0] i_waddr,
  input wire logic i_wdata,
  input wire logic [`MODE_ADDR_W-1:0] i_raddr,
  output logic o_rdata
);
  logic [`AREA_N-1:0] mem_r;
  logic [`AREA_N-1:0] mem_nxt;
  logic rdata_r;
  logic rdata_nxt;

  always_comb begin
    mem_nxt = mem_r;
    if (i_we) begin
      mem_nxt[i_waddr] = i_wdata;
    end
    rdata_nxt = mem_r[i_raddr];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mem_r <= '0;
      rdata_r <= 1'b0;
    end else begin
      mem_r <= mem_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;
endmodule

// File: design/ext_bus_pins.sv
// External bus, arbitration and system control pin logic
`timescale 1ns/1ps
`include "ext_bus_map.svh"
module ext_bus_pins
  import ext_bus_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_mode_select_pins,
  input wire logic i_chip_init_n,
  input wire logic i_hw_standby_n,
  input wire logic i_ext_bus_req_n,
  input wire logic i_flash_program_enable,
  input wire logic i_nmi_n,
  input wire logic [7:0] i_maskable_int_lines_n,
  input wire logic i_wait_n,
  input wire logic i_req,
  input wire logic i_req_write,
  input wire logic i_req_flash,
  input wire logic [`ADDR_W-1:0] i_req_addr,
  input wire logic [`DATA_W-1:0] i_req_wdata,
  input wire logic [1:0] i_req_be,
  input wire logic i_cfg_we,
  input wire logic [2:0] i_cfg_area,
  input wire logic i_cfg_three_state,
  input wire logic [`DATA_W-1:0] i_data_in,
  output logic o_req_ready,
  output logic o_done,
  output logic o_flash_reject,
  output logic [`DATA_W-1:0] o_rdata,
  output logic [2:0] o_mode,
  output logic o_mode_valid,
  output logic o_in_reset,
  output logic o_standby,
  output logic o_nmi_req,
  output logic [7:0] o_irq_req,
  output logic o_bus_ack_n,
  output logic o_internal_master_req_out_n,
  output logic [`ADDR_W-1:0] o_addr,
  output logic o_addr_oe,
  output logic [`DATA_W-1:0] o_data_out,
  output logic o_data_oe,
  output logic [`AREA_N-1:0] o_area_select_n,
  output logic o_addr_strobe_n,
  output logic o_read_n,
  output logic o_upper_byte_write_n,
  output logic o_lower_byte_write_n,
  output logic o_ctrl_oe
);
  function automatic logic [`AREA_N-1:0] area_dec(input logic [`ADDR_W-1:0] a);
    area_dec = ~(`AREA_N'(1) << a[`AREA_HI:`AREA_LO]);
  endfunction

  bus_state_e state_r, state_nxt;
  logic [`ADDR_W-1:0] addr_r, addr_nxt;
  logic [`DATA_W-1:0] wdata_r, wdata_nxt;
  logic [`DATA_W-1:0] rdata_r, rdata_nxt;
  logic [1:0] be_r, be_nxt;
  logic write_r, write_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [3:0] wcnt_r, wcnt_nxt;
  logic done_r, done_nxt;
  logic rej_r, rej_nxt;
  logic [2:0] mode_r, mode_nxt;
  logic mode_valid_r, mode_valid_nxt;
  logic nmi_r, nmi_nxt;
  logic [7:0] irq_r, irq_nxt;
  logic hold_rst;
  logic hw_standby_n;
  logic area_3s;

  assign hold_rst = ~i_chip_init_n;
  assign hw_standby_n = ~i_hw_standby_n;

  area_cfg_mem u_cfg (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_we(i_cfg_we),
    .i_waddr(i_cfg_area),
    .i_wdata(i_cfg_three_state),
    .i_raddr(addr_r[`AREA_HI:`AREA_LO]),
    .o_rdata(area_3s)
  );

  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    be_nxt = be_r;
    write_nxt = write_r;
    cnt_nxt = cnt_r;
    wcnt_nxt = wcnt_r;
    done_nxt = 1'b0;
    rej_nxt = 1'b0;
    // Mode pins are static, so sampling each cycle is safe
    mode_nxt = i_mode_select_pins;
    mode_valid_nxt = i_mode_select_pins[`MODE_TOP];
    nmi_nxt = ~i_nmi_n;
    irq_nxt = ~i_maskable_int_lines_n;
    unique case (state_r)
      ST_IDLE: begin
        if (!i_ext_bus_req_n) begin
          state_nxt = ST_RELEASED;
        end else if (i_req && i_req_write && i_req_flash && !i_flash_program_enable) begin
          rej_nxt = 1'b1;
          done_nxt = 1'b1;
        end else if (i_req) begin
          addr_nxt = i_req_addr;
          wdata_nxt = i_req_wdata;
          be_nxt = i_req_be;
          write_nxt = i_req_write;
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        cnt_nxt = `ACC_CYCLES;
        wcnt_nxt = '0;
        state_nxt = ST_DATA;
      end
      ST_DATA: begin
        if (cnt_r != 4'h0) begin
          cnt_nxt = cnt_r - 4'h1;
        end else if (!i_wait_n && area_3s && wcnt_r != `WAIT_LIMIT) begin
          wcnt_nxt = wcnt_r + 4'h1;
        end else begin
          if (!write_r) begin
            rdata_nxt = i_data_in;
          end
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        done_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_RELEASED: begin
        if (i_ext_bus_req_n) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      addr_r <= '0;
      wdata_r <= '0;
      rdata_r <= '0;
      be_r <= 2'h0;
      write_r <= 1'b0;
      cnt_r <= 4'h0;
      wcnt_r <= 4'h0;
      done_r <= 1'b0;
      rej_r <= 1'b0;
      mode_r <= 3'h0;
      mode_valid_r <= 1'b0;
      nmi_r <= 1'b0;
      irq_r <= 8'h00;
    end else if (hold_rst || hw_standby_n) begin
      state_r <= ST_IDLE;
      done_r <= 1'b0;
      rej_r <= 1'b0;
      mode_r <= mode_nxt;
      mode_valid_r <= mode_valid_nxt;
      nmi_r <= 1'b0;
      irq_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      be_r <= be_nxt;
      write_r <= write_nxt;
      cnt_r <= cnt_nxt;
      wcnt_r <= wcnt_nxt;
      done_r <= done_nxt;
      rej_r <= rej_nxt;
      mode_r <= mode_nxt;
      mode_valid_r <= mode_valid_nxt;
      nmi_r <= nmi_nxt;
      irq_r <= irq_nxt;
    end
  end

  logic active;
  logic released;
  assign active = (state_r == ST_DATA);
  assign released = (state_r == ST_RELEASED);

  assign o_req_ready = (state_r == ST_IDLE) && i_ext_bus_req_n && !hold_rst && !hw_standby_n;
  assign o_done = done_r;
  assign o_flash_reject = rej_r;
  assign o_rdata = rdata_r;
  assign o_mode = mode_valid_r ? mode_r : 3'h0;
  assign o_mode_valid = mode_valid_r;
  assign o_in_reset = hold_rst;
  assign o_standby = hw_standby_n;
  assign o_nmi_req = nmi_r;
  assign o_irq_req = irq_r;
  assign o_bus_ack_n = ~released;
  assign o_internal_master_req_out_n = ~(released && i_req);
  assign o_addr = addr_r;
  assign o_addr_oe = ~released && ~hw_standby_n;
  assign o_ctrl_oe = ~released && ~hw_standby_n;
  assign o_data_out = wdata_r;
  assign o_data_oe = active && write_r;
  assign o_area_select_n = active ? area_dec(addr_r) : {`AREA_N{1'b1}};
  assign o_addr_strobe_n = ~active;
  assign o_read_n = ~(active && !write_r);
  assign o_upper_byte_write_n = ~(active && write_r && be_r[1]);
  assign o_lower_byte_write_n = ~(active && write_r && be_r[0]);
endmodule

// File: dv/ext_bus_pins_asserts.sv
// Checker for the external bus pin block
`timescale 1ns/1ps
`include "ext_bus_map.svh"
module ext_bus_pins_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_chip_init_n,
  input wire logic i_hw_standby_n,
  input wire logic i_ext_bus_req_n,
  input wire logic i_flash_program_enable,
  input wire logic [7:0] i_maskable_int_lines_n,
  input wire logic i_req,
  input wire logic i_req_write,
  input wire logic i_req_flash,
  input wire logic o_req_ready,
  input wire logic o_done,
  input wire logic o_flash_reject,
  input wire logic [2:0] o_mode,
  input wire logic o_mode_valid,
  input wire logic o_standby,
  input wire logic [7:0] o_irq_req,
  input wire logic o_bus_ack_n,
  input wire logic o_internal_master_req_out_n,
  input wire logic [`ADDR_W-1:0] o_addr,
  input wire logic o_addr_oe,
  input wire logic o_data_oe,
  input wire logic [`AREA_N-1:0] o_area_select_n,
  input wire logic o_addr_strobe_n,
  input wire logic o_read_n,
  input wire logic o_upper_byte_write_n,
  input wire logic o_ctrl_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_MODE: assert property (o_mode_valid == o_mode[2] && (o_mode_valid || o_mode == 3'h0))
    else $error("mode output inconsistent");
  AST_INIT: assert property (!i_chip_init_n |=> !o_done && o_irq_req == 8'h00)
    else $error("init hold not applied");
  AST_HW_STANDBY_N: assert property (o_standby == !i_hw_standby_n)
    else $error("standby output wrong");
  AST_ACK: assert property ($fell(o_bus_ack_n) |-> $past(!i_ext_bus_req_n))
    else $error("bus released without request");
  AST_BRQO: assert property (o_internal_master_req_out_n == !(!o_bus_ack_n && i_req))
    else $error("request out wrong");
  AST_FLOAT: assert property (!o_bus_ack_n |-> !o_addr_oe && !o_ctrl_oe && !o_data_oe)
    else $error("outputs driven while released");
  AST_FLASH: assert property (i_req && o_req_ready && i_req_write && i_req_flash
    && !i_flash_program_enable |=> o_flash_reject && o_done)
    else $error("flash write not rejected");
  AST_IRQ: assert property (!$past(i_rst) && $past(i_chip_init_n) && $past(i_hw_standby_n)
    |-> o_irq_req == ~$past(i_maskable_int_lines_n))
    else $error("irq copy wrong");
  AST_AREA: assert property (!o_addr_strobe_n
    |-> o_area_select_n == ~(8'h01 << o_addr[23:21]))
    else $error("area select wrong");
  AST_RD: assert property (!o_read_n |-> !o_addr_strobe_n && !o_data_oe)
    else $error("read strobe wrong");
  AST_WR: assert property (!o_upper_byte_write_n |-> o_data_oe && o_read_n)
    else $error("write strobe without data");
  COV_ACK: cover property ($fell(o_bus_ack_n));
  COV_REJ: cover property (o_flash_reject);
  COV_RD: cover property ($fell(o_read_n));
endmodule
bind ext_bus_pins ext_bus_pins_chk u_ext_bus_pins_chk (.i_clk, .i_rst, .i_chip_init_n,
  .i_hw_standby_n, .i_ext_bus_req_n, .i_flash_program_enable, .i_maskable_int_lines_n,
  .i_req, .i_req_write, .i_req_flash, .o_req_ready, .o_done, .o_flash_reject, .o_mode,
  .o_mode_valid, .o_standby, .o_irq_req, .o_bus_ack_n, .o_internal_master_req_out_n,
  .o_addr, .o_addr_oe, .o_data_oe, .o_area_select_n, .o_addr_strobe_n, .o_read_n,
  .o_upper_byte_write_n, .o_ctrl_oe);

// File: dv/ext_mem_model.sv
// External memory on the far side of the bus
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic i_clk,
  input wire logic [23:0] i_addr,
  input wire logic i_read_n,
  output logic [15:0] o_data
);
  logic [15:0] last_r = 16'h0;
  always_ff @(posedge i_clk) last_r <= o_data;
  // Drives only while read strobe low, else toggles
  always_comb o_data = !i_read_n ? (i_addr[15:0] ^ 16'ha5c3) : ~last_r;
endmodule

// File: dv/ext_bus_pins_tb.sv
// Bench for the external bus pin block
`timescale 1ns/1ps
`include "ext_bus_map.svh"
module ext_bus_pins_tb;
  logic i_clk = 0, i_rst = 1, cin = 1, stb = 1, ext_bus_req_n = 1, fpe = 1, rq = 0, rw = 0, rf = 0;
  logic wt = 1, cwe = 0, c3 = 0, ack_n, rqo_n, rdy, dn, rej, u_n, l_n, rd_n, su, sl, mv, irs;
  logic nmi_n = 1, nmi, sb;
  logic [2:0] mode = 3'h6, carea = 3'h0, om;
  logic [1:0] be = 2'h0;
  logic [7:0] irq_n = 8'hff, oirq;
  logic [23:0] ra = 24'h0, oa;
  logic [15:0] wd = 16'h0, din, rdat, dout, sd;
  int mismatches = 0, samples_checked = 0, n;
  typedef struct {logic w; logic f; logic [1:0] b; logic [23:0] a; logic [15:0] d;} row_s;
  row_s rows[7] = '{'{0, 0, 2'h3, 24'h000123, 16'h0}, '{0, 0, 2'h3, 24'he0abcd, 16'h0},
    '{1, 0, 2'h3, 24'h6000f0, 16'h1234}, '{1, 0, 2'h2, 24'h400002, 16'hbeef},
    '{1, 0, 2'h1, 24'h800004, 16'h00c5}, '{1, 0, 2'h0, 24'h200006, 16'h7777},
    '{1, 1, 2'h3, 24'ha00008, 16'h5a5a}};
  ext_bus_pins u_ext_bus_pins (.i_clk, .i_rst, .i_mode_select_pins(mode), .i_chip_init_n(cin),
    .i_hw_standby_n(stb), .i_ext_bus_req_n(ext_bus_req_n), .i_flash_program_enable(fpe), .i_nmi_n(nmi_n),
    .i_maskable_int_lines_n(irq_n), .i_wait_n(wt), .i_req(rq), .i_req_write(rw),
    .i_req_flash(rf), .i_req_addr(ra), .i_req_wdata(wd), .i_req_be(be), .i_cfg_we(cwe),
    .i_cfg_area(carea), .i_cfg_three_state(c3), .i_data_in(din), .o_req_ready(rdy),
    .o_done(dn), .o_flash_reject(rej), .o_rdata(rdat), .o_mode(om), .o_mode_valid(mv),
    .o_in_reset(irs), .o_standby(sb), .o_nmi_req(nmi), .o_irq_req(oirq), .o_bus_ack_n(ack_n),
    .o_internal_master_req_out_n(rqo_n), .o_addr(oa), .o_addr_oe(), .o_data_out(dout),
    .o_data_oe(), .o_area_select_n(), .o_addr_strobe_n(), .o_read_n(rd_n),
    .o_upper_byte_write_n(u_n), .o_lower_byte_write_n(l_n), .o_ctrl_oe());
  ext_mem_model u_ext_mem_model (.i_clk, .i_addr(oa), .i_read_n(rd_n), .o_data(din));
  initial forever #5 i_clk = ~i_clk;
  always @(posedge i_clk) if (!u_n || !l_n) {su, sl, sd} <= {~u_n, ~l_n, dout};
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic acc(input row_s r);
    {rw, rf, be, ra, wd} = {r.w, r.f, r.b, r.a, r.d};
    {su, sl, sd} = '0;
    rq = 1;
    n = 0;
    while (!rdy && n < 40) begin step(1); n++; end
    step(1);
    rq = 0;
    n = 0;
    while (!dn && n < 60) begin step(1); n++; end
  endtask
  task automatic test_done;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
  initial begin
    step(10);
    i_rst = 0;
    step(2);
    foreach (rows[i]) begin
      acc(rows[i]);
      chk(24'(n), 24'd5);
      if (!rows[i].w) chk(24'(rdat), 24'(rows[i].a[15:0] ^ 16'ha5c3));
      else chk({su, sl, sd}, {rows[i].b, (rows[i].b != 0) ? rows[i].d : 16'h0});
    end
    fpe = 0;
    acc(rows[6]);
    chk({24'(n), rej}, {24'd0, 1'b1});
    fpe = 1;
    {cwe, carea, c3} = {1'b1, 3'h1, 1'b1};
    step(1);
    {cwe, wt} = 2'b00;
    acc('{0, 0, 2'h3, 24'h200010, 16'h0});
    chk(24'(n > 5), 24'h1);
    acc(rows[0]);
    chk(24'(n), 24'd5);
    wt = 1;
    ext_bus_req_n = 0;
    step(2);
    rq = 1;
    step(1);
    chk({ack_n, rqo_n, rdy}, 3'h0);
    {rq, ext_bus_req_n} = 2'b01;
    step(2);
    chk(ack_n, 1'b1);
    irq_n = 8'h5a;
    nmi_n = 0;
    step(1);
    chk(oirq, 8'ha5);
    chk(nmi, 1'b1);
    cin = 0;
    step(1);
    chk({irs, oirq, nmi}, 10'h200);
    {cin, stb} = 2'b10;
    step(1);
    chk({sb, oirq, nmi}, 10'h200);
    stb = 1;
    for (int m = 0; m < 8; m++) begin
      i_rst = 1;
      mode = m[2:0]; // Mode pins change only under reset
      step(1);
      i_rst = 0;
      step(2);
      chk({mv, om}, {m[2], m[2] ? m[2:0] : 3'h0});
    end
    test_done;
  end
endmodule
